// ---- rtl/bbd_branch_bit_decoder.v ----
// Summary of operation
// - 0x73 one byte, 2 cycles, pc = acc+pointer
// - 0x60 two bytes, 3 cycles, branch if acc zero
// - 0x70 two bytes, 3 cycles, branch if acc nonzero
// - 0x40 two bytes, 3 cycles, branch if carry
// - 0x50 two bytes, 3 cycles, branch if no carry
// - 0x20 three bytes, 4 cycles, branch if bit set
// - 0x30 three bytes, 4 cycles, branch if bit clear
// - 0x10 three bytes, 4 cycles, branch, clear set bit
// - 0xB5 three bytes, 4 cycles, branch if differ
// - 0xB4 three bytes, 4 cycles, branch if differ
// - 0xB8-0xBF register compare, 4 cycles, unequal branch
// - 0xB6/0xB7 indirect compare, 4 cycles, unequal branch
// - 0xD8-0xDF register decrement, 3 cycles, nonzero branch
// - 0xD5 direct decrement, write back, nonzero branch
// - 0x82 and bit into carry, 2 cycles
// - 0xB0 and inverse bit into carry
// - 0x72 or bit into carry, 2 cycles
// - 0xA0 or inverse bit into carry
// - 0xA2 copy bit to carry, 2 cycles
// - 0x92 copy carry to bit, 3 cycles
`include "bbd_defs.vh"

module bbd_branch_bit_decoder (
    input  wire        REF_CLK_I,
    input  wire        RESET_N_I,
    input  wire        INSTR_VALID_I,
    output wire        INSTR_READY_O,
    input  wire [7:0]  OPCODE_I,
    input  wire [7:0]  OPERAND1_I,
    input  wire [7:0]  OPERAND2_I,
    input  wire [15:0] PC_I,
    input  wire [7:0]  ACC_I,
    input  wire [15:0] DATA_POINTER_I,
    input  wire        CARRY_I,
    input  wire [1:0]  BANK_I,
    output wire        BYTE_RD_EN_O,
    output wire [7:0]  BYTE_RD_ADDR_O,
    input  wire [7:0]  BYTE_RD_DATA_I,
    output wire        BIT_RD_EN_O,
    output wire [7:0]  BIT_RD_ADDR_O,
    input  wire        BIT_RD_DATA_I,
    output reg         BYTE_WR_EN_O,
    output reg  [7:0]  BYTE_WR_ADDR_O,
    output reg  [7:0]  BYTE_WR_DATA_O,
    output reg         BIT_WR_EN_O,
    output reg  [7:0]  BIT_WR_ADDR_O,
    output reg         BIT_WR_DATA_O,
    output reg         CARRY_WR_EN_O,
    output reg         CARRY_O,
    output reg         DONE_O,
    output reg         TAKEN_O,
    output reg         UNKNOWN_O,
    output reg  [15:0] NEXT_PC_O
);

    // -----------------------------------------------------------------
    // instruction classes
    // -----------------------------------------------------------------
    localparam [4:0] C_NONE   = 5'h00;
    localparam [4:0] C_IJMP   = 5'h01;
    localparam [4:0] C_JZ     = 5'h02;
    localparam [4:0] C_JNZ    = 5'h03;
    localparam [4:0] C_JC     = 5'h04;
    localparam [4:0] C_JNC    = 5'h05;
    localparam [4:0] C_JB     = 5'h06;
    localparam [4:0] C_JNB    = 5'h07;
    localparam [4:0] C_JBC    = 5'h08;
    localparam [4:0] C_CMPD   = 5'h09;
    localparam [4:0] C_CMPA   = 5'h0A;
    localparam [4:0] C_CMPR   = 5'h0B;
    localparam [4:0] C_CMPI   = 5'h0C;
    localparam [4:0] C_DECR   = 5'h0D;
    localparam [4:0] C_DECD   = 5'h0E;
    localparam [4:0] C_ANDB   = 5'h0F;
    localparam [4:0] C_ANDN   = 5'h10;
    localparam [4:0] C_ORB    = 5'h11;
    localparam [4:0] C_ORN    = 5'h12;
    localparam [4:0] C_B2C    = 5'h13;
    localparam [4:0] C_C2B    = 5'h14;

    localparam       S_IDLE   = 1'b0;
    localparam       S_BUSY   = 1'b1;

    // -----------------------------------------------------------------
    // decode: {class, length, cycles}
    // -----------------------------------------------------------------
    function [9:0] decode;
        input [7:0] op;
        begin
            decode = {C_NONE, `BBD_LEN_ONE, `BBD_CYC_ONE};
            if ((op & `BBD_REG_GROUP_MASK) == `BBD_OP_CMP_REG_BASE)
                decode = {C_CMPR, `BBD_LEN_THREE, `BBD_CYC_FOUR};
            else if ((op & `BBD_REG_GROUP_MASK) == `BBD_OP_DEC_REG_BASE)
                decode = {C_DECR, `BBD_LEN_TWO, `BBD_CYC_THREE};
            else begin
                case (op)
                    `BBD_OP_INDIRECT_JUMP:  decode = {C_IJMP, `BBD_LEN_ONE, `BBD_CYC_TWO};
                    `BBD_OP_JUMP_ACC_ZERO:  decode = {C_JZ, `BBD_LEN_TWO, `BBD_CYC_THREE};
                    `BBD_OP_JUMP_ACC_NZERO: decode = {C_JNZ, `BBD_LEN_TWO, `BBD_CYC_THREE};
                    `BBD_OP_JUMP_CARRY:     decode = {C_JC, `BBD_LEN_TWO, `BBD_CYC_THREE};
                    `BBD_OP_JUMP_NO_CARRY:  decode = {C_JNC, `BBD_LEN_TWO, `BBD_CYC_THREE};
                    `BBD_OP_JUMP_BIT_SET:   decode = {C_JB, `BBD_LEN_THREE, `BBD_CYC_FOUR};
                    `BBD_OP_JUMP_BIT_CLEAR: decode = {C_JNB, `BBD_LEN_THREE, `BBD_CYC_FOUR};
                    `BBD_OP_TEST_CLEAR:     decode = {C_JBC, `BBD_LEN_THREE, `BBD_CYC_FOUR};
                    `BBD_OP_CMP_ACC_DIRECT: decode = {C_CMPD, `BBD_LEN_THREE, `BBD_CYC_FOUR};
                    `BBD_OP_CMP_ACC_IMM:    decode = {C_CMPA, `BBD_LEN_THREE, `BBD_CYC_FOUR};
                    `BBD_OP_CMP_IND_R0,
                    `BBD_OP_CMP_IND_R1:     decode = {C_CMPI, `BBD_LEN_THREE, `BBD_CYC_FOUR};
                    `BBD_OP_DEC_DIRECT:     decode = {C_DECD, `BBD_LEN_THREE, `BBD_CYC_FOUR};
                    `BBD_OP_AND_BIT:        decode = {C_ANDB, `BBD_LEN_TWO, `BBD_CYC_TWO};
                    `BBD_OP_AND_INV_BIT:    decode = {C_ANDN, `BBD_LEN_TWO, `BBD_CYC_TWO};
                    `BBD_OP_OR_BIT:         decode = {C_ORB, `BBD_LEN_TWO, `BBD_CYC_TWO};
                    `BBD_OP_OR_INV_BIT:     decode = {C_ORN, `BBD_LEN_TWO, `BBD_CYC_TWO};
                    `BBD_OP_COPY_BIT_CARRY: decode = {C_B2C, `BBD_LEN_TWO, `BBD_CYC_TWO};
                    `BBD_OP_COPY_CARRY_BIT: decode = {C_C2B, `BBD_LEN_TWO, `BBD_CYC_THREE};
                    default:                decode = {C_NONE, `BBD_LEN_ONE, `BBD_CYC_ONE};
                endcase
            end
        end
    endfunction

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    reg        state_q;
    reg [2:0]  cnt_q;
    reg [4:0]  cls_q;
    reg [1:0]  len_q;
    reg [2:0]  cyc_q;
    reg [7:0]  op_q;
    reg [7:0]  opnd1_q;
    reg [7:0]  opnd2_q;
    reg [15:0] pc_q;
    reg [7:0]  acc_q;
    reg [15:0] data_pointer_q;
    reg        carry_q;
    reg [1:0]  bank_q;
    reg [7:0]  data_q;
    reg        bit_q;

    wire [9:0] dec_w   = decode(OPCODE_I);
    wire       accept  = (state_q == S_IDLE) && INSTR_VALID_I;
    assign INSTR_READY_O = (state_q == S_IDLE);

    wire [7:0] reg_addr  = {3'h0, bank_q, op_q[`BBD_REG_SEL_MSB:0]};
    wire [7:0] ind_addr  = {3'h0, bank_q, 2'h0, op_q[0]};
    wire       in_first  = (state_q == S_BUSY) && (cnt_q == 3'h1);
    wire       in_second = (state_q == S_BUSY) && (cnt_q == 3'h2);

    // -----------------------------------------------------------------
    // operand reads, zero-latency: data is valid in the strobe cycle
    // -----------------------------------------------------------------
    wire rd_direct = (cls_q == C_CMPD) || (cls_q == C_DECD);
    wire rd_reg    = (cls_q == C_CMPR) || (cls_q == C_DECR);
    wire rd_ind    = (cls_q == C_CMPI);
    wire rd_bit    = (cls_q == C_JB) || (cls_q == C_JNB) || (cls_q == C_JBC) ||
                     (cls_q == C_ANDB) || (cls_q == C_ANDN) || (cls_q == C_ORB) ||
                     (cls_q == C_ORN) || (cls_q == C_B2C);

    // indirect compare needs two reads: pointer register, then target
    assign BYTE_RD_EN_O   = (in_first && (rd_direct || rd_reg || rd_ind)) ||
                            (in_second && rd_ind);
    assign BYTE_RD_ADDR_O = in_second ? data_q :
                            rd_direct ? opnd1_q :
                            rd_reg    ? reg_addr : ind_addr;
    assign BIT_RD_EN_O    = in_first && rd_bit;
    assign BIT_RD_ADDR_O  = opnd1_q;

    // -----------------------------------------------------------------
    // result evaluation
    // -----------------------------------------------------------------
    reg        take;
    reg        carry_we;
    reg        carry_new;
    reg        bwr;
    reg        bwr_val;
    reg        ywr;
    reg [7:0]  rel;
    wire [7:0] dec_val = data_q - 8'h01;
    wire       bit_now = in_first ? BIT_RD_DATA_I : bit_q; // two-cycle bit ops finish in their read cycle
    // offset is relative to the address after the whole instruction
    wire [15:0] seq_pc = pc_q + {14'h0, len_q};

    always @* begin
        take      = 1'b0;
        carry_we  = 1'b0;
        carry_new = carry_q;
        bwr       = 1'b0;
        bwr_val   = 1'b0;
        ywr       = 1'b0;
        rel       = (len_q == `BBD_LEN_THREE) ? opnd2_q : opnd1_q;
        case (cls_q)
            C_JZ:   take = (acc_q == 8'h00);
            C_JNZ:  take = (acc_q != 8'h00);
            C_JC:   take = carry_q;
            C_JNC:  take = ~carry_q;
            C_JB:   take = bit_q;
            C_JNB:  take = ~bit_q;
            C_JBC: begin
                take    = bit_q;
                bwr     = bit_q;
                bwr_val = 1'b0;
            end
            C_CMPD: take = (data_q != acc_q);
            C_CMPA: take = (opnd1_q != acc_q);
            C_CMPR: take = (data_q != opnd1_q);
            C_CMPI: take = (data_q != opnd1_q);
            C_DECR: begin
                take = (dec_val != 8'h00);
                ywr  = 1'b1;
            end
            C_DECD: begin
                take = (dec_val != 8'h00);
                ywr  = 1'b1;
            end
            C_ANDB: begin
                carry_we  = 1'b1;
                carry_new = carry_q & bit_now;
            end
            C_ANDN: begin
                carry_we  = 1'b1;
                carry_new = carry_q & ~bit_now;
            end
            C_ORB: begin
                carry_we  = 1'b1;
                carry_new = carry_q | bit_now;
            end
            C_ORN: begin
                carry_we  = 1'b1;
                carry_new = carry_q | ~bit_now;
            end
            C_B2C: begin
                carry_we  = 1'b1;
                carry_new = bit_now;
            end
            C_C2B: begin
                bwr     = 1'b1;
                bwr_val = carry_q;
            end
            default: take = 1'b0;
        endcase
    end

    wire [15:0] rel_ext = {{8{rel[7]}}, rel};
    wire [15:0] tgt_pc  = (cls_q == C_IJMP) ? ({8'h00, acc_q} + data_pointer_q) : (seq_pc + rel_ext);
    wire        jump    = (cls_q == C_IJMP) || take;
    wire        finish  = (state_q == S_BUSY) && (cnt_q == cyc_q - 3'h1);

    // -----------------------------------------------------------------
    // sequencer: outputs land in the last cycle of the instruction
    // -----------------------------------------------------------------
    always @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            state_q        <= S_IDLE;
            cnt_q          <= 3'h0;
            cls_q          <= C_NONE;
            len_q          <= 2'h0;
            cyc_q          <= 3'h0;
            op_q           <= 8'h00;
            opnd1_q        <= 8'h00;
            opnd2_q        <= 8'h00;
            pc_q           <= 16'h0000;
            acc_q          <= 8'h00;
            data_pointer_q         <= 16'h0000;
            carry_q        <= 1'b0;
            bank_q         <= 2'h0;
            data_q         <= 8'h00;
            bit_q          <= 1'b0;
            DONE_O         <= 1'b0;
            TAKEN_O        <= 1'b0;
            UNKNOWN_O      <= 1'b0;
            NEXT_PC_O      <= 16'h0000;
            CARRY_WR_EN_O  <= 1'b0;
            CARRY_O        <= 1'b0;
            BIT_WR_EN_O    <= 1'b0;
            BIT_WR_ADDR_O  <= 8'h00;
            BIT_WR_DATA_O  <= 1'b0;
            BYTE_WR_EN_O   <= 1'b0;
            BYTE_WR_ADDR_O <= 8'h00;
            BYTE_WR_DATA_O <= 8'h00;
        end else begin
            DONE_O        <= 1'b0;
            TAKEN_O       <= 1'b0;
            UNKNOWN_O     <= 1'b0;
            CARRY_WR_EN_O <= 1'b0;
            BIT_WR_EN_O   <= 1'b0;
            BYTE_WR_EN_O  <= 1'b0;
            case (state_q)
                S_IDLE: begin
                    if (accept) begin
                        {cls_q, len_q, cyc_q} <= dec_w;
                        op_q    <= OPCODE_I;
                        opnd1_q <= OPERAND1_I;
                        opnd2_q <= OPERAND2_I;
                        pc_q    <= PC_I;
                        acc_q   <= ACC_I;
                        data_pointer_q  <= DATA_POINTER_I;
                        carry_q <= CARRY_I;
                        bank_q  <= BANK_I;
                        cnt_q   <= 3'h1;
                        // unknown opcodes retire in one cycle, pc steps by one
                        if (dec_w[9:5] == C_NONE) begin
                            DONE_O    <= 1'b1;
                            UNKNOWN_O <= 1'b1;
                            NEXT_PC_O <= PC_I + 16'h0001;
                        end else begin
                            state_q <= S_BUSY;
                        end
                    end
                end
                S_BUSY: begin
                    cnt_q <= cnt_q + 3'h1;
                    if (in_first) begin
                        data_q <= BYTE_RD_DATA_I;
                        bit_q  <= BIT_RD_DATA_I;
                    end
                    if (in_second && rd_ind)
                        data_q <= BYTE_RD_DATA_I;
                    if (finish) begin
                        // full count is spent whether or not the branch goes
                        DONE_O         <= 1'b1;
                        TAKEN_O        <= jump;
                        NEXT_PC_O      <= jump ? tgt_pc : seq_pc;
                        CARRY_WR_EN_O  <= carry_we;
                        CARRY_O        <= carry_new;
                        BIT_WR_EN_O    <= bwr;
                        BIT_WR_ADDR_O  <= opnd1_q;
                        BIT_WR_DATA_O  <= bwr_val;
                        BYTE_WR_EN_O   <= ywr;
                        BYTE_WR_ADDR_O <= (cls_q == C_DECR) ? reg_addr : opnd1_q;
                        BYTE_WR_DATA_O <= dec_val;
                    end
                    if (cnt_q == cyc_q)
                        state_q <= S_IDLE;
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

endmodule // bbd_branch_bit_decoder

// ---- include/bbd_defs.vh ----
`ifndef BBD_DEFS_VH
`define BBD_DEFS_VH

// -----------------------------------------------------------------
// opcodes
// -----------------------------------------------------------------
`define BBD_OP_INDIRECT_JUMP   8'h73
`define BBD_OP_JUMP_ACC_ZERO   8'h60
`define BBD_OP_JUMP_ACC_NZERO  8'h70
`define BBD_OP_JUMP_CARRY      8'h40
`define BBD_OP_JUMP_NO_CARRY   8'h50
`define BBD_OP_JUMP_BIT_SET    8'h20
`define BBD_OP_JUMP_BIT_CLEAR  8'h30
`define BBD_OP_TEST_CLEAR      8'h10
`define BBD_OP_CMP_ACC_DIRECT  8'hB5
`define BBD_OP_CMP_ACC_IMM     8'hB4
`define BBD_OP_CMP_IND_R0      8'hB6
`define BBD_OP_CMP_IND_R1      8'hB7
`define BBD_OP_CMP_REG_BASE    8'hB8
`define BBD_OP_DEC_REG_BASE    8'hD8
`define BBD_OP_DEC_DIRECT      8'hD5
`define BBD_OP_AND_BIT         8'h82
`define BBD_OP_AND_INV_BIT     8'hB0
`define BBD_OP_OR_BIT          8'h72
`define BBD_OP_OR_INV_BIT      8'hA0
`define BBD_OP_COPY_BIT_CARRY  8'hA2
`define BBD_OP_COPY_CARRY_BIT  8'h92

// -----------------------------------------------------------------
// field positions and lengths
// -----------------------------------------------------------------
`define BBD_REG_SEL_MSB        2
`define BBD_REG_GROUP_MASK     8'hF8
`define BBD_LEN_ONE            2'h1
`define BBD_LEN_TWO            2'h2
`define BBD_LEN_THREE          2'h3

// -----------------------------------------------------------------
// execution times in machine cycles
// -----------------------------------------------------------------
`define BBD_CYC_ONE            3'h1
`define BBD_CYC_TWO            3'h2
`define BBD_CYC_THREE          3'h3
`define BBD_CYC_FOUR           3'h4

`endif

// ---- verification/bbd_monitor.sv ----
// ------------------------------------------
// decoder port checker
// ------------------------------------------
module bbd_monitor (
    input wire        REF_CLK_I,
    input wire        RESET_N_I,
    input wire        INSTR_VALID_I,
    input wire        INSTR_READY_O,
    input wire [7:0]  OPCODE_I,
    input wire [7:0]  OPERAND1_I,
    input wire [15:0] PC_I,
    input wire [7:0]  ACC_I,
    input wire [15:0] DATA_POINTER_I,
    input wire        CARRY_I,
    input wire        BYTE_WR_EN_O,
    input wire        BIT_WR_EN_O,
    input wire        CARRY_WR_EN_O,
    input wire        DONE_O,
    input wire        TAKEN_O,
    input wire [15:0] NEXT_PC_O
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  op_q, acc_q, rel_q;
    logic [15:0] pc_q, ptr_q;
    logic        cy_q;
    logic [2:0]  cnt_q;
    wire         take = INSTR_VALID_I && INSTR_READY_O;
    wire  [15:0] rel = {{8{rel_q[7]}}, rel_q};
    wire         is_flag = op_q inside {8'h60, 8'h70, 8'h40, 8'h50};
    wire         cond = op_q[5] ? (op_q[4] ^ (acc_q == 8'h00)) : (op_q[4] ^ cy_q);
    // snapshot at take, the core may move its inputs afterwards
    always @(posedge REF_CLK_I) begin
        if (take) begin
            op_q <= OPCODE_I;
            acc_q <= ACC_I;
            rel_q <= OPERAND1_I;
            pc_q <= PC_I;
            ptr_q <= DATA_POINTER_I;
            cy_q <= CARRY_I;
        end
    end
    always @(posedge REF_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) cnt_q <= 3'h0;
        else if (take) cnt_q <= 3'h1;
        else if (DONE_O) cnt_q <= 3'h0;
        else if (cnt_q != 3'h0) cnt_q <= cnt_q + 3'h1;
    end
    function automatic [2:0] cyc(input [7:0] op);
        cyc = 3'h1;
        if (op inside {8'h73, 8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2}) cyc = 3'h2;
        if (op inside {8'h60, 8'h70, 8'h40, 8'h50, 8'h92} || (op & 8'hF8) == 8'hD8) cyc = 3'h3;
        if (op inside {8'h20, 8'h30, 8'h10, 8'hB4, 8'hB5, 8'hB6, 8'hB7, 8'hD5} || (op & 8'hF8) == 8'hB8) cyc = 3'h4;
    endfunction
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RESET_N_I);
    property p_refuse; take && cyc(OPCODE_I) != 3'h1 |=> !INSTR_READY_O [*2]; endproperty
    a_refuse: assert property (p_refuse) else $error("ready back too soon");
    property p_bound; take |-> ##[1:4] DONE_O; endproperty
    a_bound: assert property (p_bound) else $error("no done within four cycles");
    property p_cyc; DONE_O |-> cnt_q == cyc(op_q); endproperty
    a_cyc: assert property (p_cyc) else $error("wrong cycle count");
    property p_ind; DONE_O && op_q == 8'h73 |-> TAKEN_O && NEXT_PC_O == ptr_q + {8'h00, acc_q}; endproperty
    a_ind: assert property (p_ind) else $error("indirect jump target");
    property p_flag; DONE_O && is_flag |-> TAKEN_O == cond; endproperty
    a_flag: assert property (p_flag) else $error("flag branch decision");
    property p_rel; DONE_O && is_flag |-> NEXT_PC_O == pc_q + 16'h0002 + (TAKEN_O ? rel : 16'h0000); endproperty
    a_rel: assert property (p_rel) else $error("relative target");
    property p_cwe; CARRY_WR_EN_O |-> DONE_O && op_q inside {8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2}; endproperty
    a_cwe: assert property (p_cwe) else $error("stray carry write");
    property p_wr; BYTE_WR_EN_O || BIT_WR_EN_O |-> DONE_O; endproperty
    a_wr: assert property (p_wr) else $error("write outside last cycle");
    c_taken: cover property (DONE_O && TAKEN_O);
    c_skip: cover property (DONE_O && !TAKEN_O);
    c_carry: cover property (CARRY_WR_EN_O);
endmodule // bbd_monitor

// ---- verification/bbd_mem_model.sv ----
// ------------------------------------------
// internal data memory, zero-latency reads
// ------------------------------------------
module bbd_mem_model (
    input  wire       clk_i,
    input  wire       byte_rd_en_i,
    input  wire [7:0] byte_rd_addr_i,
    output wire [7:0] byte_rd_data_o,
    input  wire       bit_rd_en_i,
    input  wire [7:0] bit_rd_addr_i,
    output wire       bit_rd_data_o,
    input  wire       byte_wr_en_i,
    input  wire [7:0] byte_wr_addr_i,
    input  wire [7:0] byte_wr_data_i,
    input  wire       bit_wr_en_i,
    input  wire [7:0] bit_wr_addr_i,
    input  wire       bit_wr_data_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256];
    logic [7:0] last_q = 8'h00;
    function automatic [7:0] bix(input [7:0] a);
        bix = a[7] ? {a[7:3], 3'h0} : 8'h20 + {4'h0, a[6:3]};
    endfunction
    // unselected reads show the inverse so a late sample cannot pass by luck
    assign byte_rd_data_o = byte_rd_en_i ? mem[byte_rd_addr_i] : ~last_q;
    assign bit_rd_data_o = bit_rd_en_i ? mem[bix(bit_rd_addr_i)][bit_rd_addr_i[2:0]] : ~last_q[0];
    always @(posedge clk_i) begin
        if (byte_rd_en_i) last_q <= byte_rd_data_o;
        if (byte_wr_en_i) mem[byte_wr_addr_i] <= byte_wr_data_i;
        if (bit_wr_en_i) mem[bix(bit_wr_addr_i)][bit_wr_addr_i[2:0]] <= bit_wr_data_i;
    end
endmodule // bbd_mem_model

// ---- verification/bbd_branch_bit_decoder_tb.sv ----
// ------------------------------------------
// decoder bench
// ------------------------------------------
module bbd_branch_bit_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, vld, cy, r_tk, r_cy, r_cwe, r_unk;
    logic [7:0]  op, o1, o2, acc;
    logic [15:0] pc, dp, r_pc;
    logic [1:0]  bank;
    logic [2:0]  ncyc;
    wire         rdy, b_re, t_re, t_rd, b_we, t_we, t_wd, c_we, c_o, done, tk, unk;
    wire  [7:0]  b_ra, b_rd, t_ra, b_wa, b_wd, t_wa;
    wire  [15:0] npc;
    int          failures, checks_done;
    logic [7:0]  jops [4] = '{8'h60, 8'h70, 8'h40, 8'h50};
    logic [7:0]  bops [3] = '{8'h20, 8'h30, 8'h10};
    logic [7:0]  cops [5] = '{8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2};

    bbd_branch_bit_decoder bbd_branch_bit_decoder_i (
        .REF_CLK_I(clk), .RESET_N_I(rst_n), .INSTR_VALID_I(vld), .INSTR_READY_O(rdy),
        .OPCODE_I(op), .OPERAND1_I(o1), .OPERAND2_I(o2), .PC_I(pc), .ACC_I(acc),
        .DATA_POINTER_I(dp), .CARRY_I(cy), .BANK_I(bank),
        .BYTE_RD_EN_O(b_re), .BYTE_RD_ADDR_O(b_ra), .BYTE_RD_DATA_I(b_rd),
        .BIT_RD_EN_O(t_re), .BIT_RD_ADDR_O(t_ra), .BIT_RD_DATA_I(t_rd),
        .BYTE_WR_EN_O(b_we), .BYTE_WR_ADDR_O(b_wa), .BYTE_WR_DATA_O(b_wd),
        .BIT_WR_EN_O(t_we), .BIT_WR_ADDR_O(t_wa), .BIT_WR_DATA_O(t_wd),
        .CARRY_WR_EN_O(c_we), .CARRY_O(c_o), .DONE_O(done), .TAKEN_O(tk), .UNKNOWN_O(unk), .NEXT_PC_O(npc));
    bbd_mem_model bbd_mem_model_i (
        .clk_i(clk), .byte_rd_en_i(b_re), .byte_rd_addr_i(b_ra), .byte_rd_data_o(b_rd),
        .bit_rd_en_i(t_re), .bit_rd_addr_i(t_ra), .bit_rd_data_o(t_rd),
        .byte_wr_en_i(b_we), .byte_wr_addr_i(b_wa), .byte_wr_data_i(b_wd),
        .bit_wr_en_i(t_we), .bit_wr_addr_i(t_wa), .bit_wr_data_i(t_wd));

    function automatic [7:0] at(input [7:0] a);
        at = bbd_mem_model_i.mem[a];
    endfunction
    task automatic put(input [7:0] a, input [7:0] v);
        bbd_mem_model_i.mem[a] <= v;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // one whole instruction: offer, wait for take, then for done, bounded
    task automatic issue(input [7:0] p_op, input [7:0] p_o1, input [7:0] p_o2);
        op <= p_op;
        o1 <= p_o1;
        o2 <= p_o2;
        vld <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        vld <= 1'b0;
        ncyc = 3'h0;
        do begin
            @(posedge clk);
            ncyc++;
        end while (done !== 1'b1 && ncyc < 3'h6);
        r_tk = tk;
        r_pc = npc;
        r_cy = c_o;
        r_cwe = c_we;
        r_unk = unk;
    endtask
    task automatic chk_br(input logic t, input logic [15:0] p, input logic [2:0] n);
        chk(r_tk, t, "taken");
        chk(r_pc, p, "next pc");
        chk(ncyc, n, "cycles");
        chk(r_unk, 1'b0, "unknown flag");
    endtask
    task automatic t_jumps;
        logic e;
        acc <= 8'hFF;
        dp <= 16'hFFF0;
        issue(8'h73, 8'h00, 8'h00);
        chk_br(1'b1, 16'h00EF, 3'h2);
        issue(8'hA5, 8'h00, 8'h00);
        chk({r_unk, r_tk, ncyc}, {2'h2, 3'h1}, "unknown op");
        chk(r_pc, 16'h0001, "unknown next pc");
        for (int i = 0; i < 8; i++) begin
            acc <= {7'h00, !i[0]};
            cy <= i[0];
            pc <= 16'h0010;
            e = i[0] ^ i[1];
            issue(jops[i[2:1]], 8'h80, 8'h00);
            chk_br(e, e ? 16'hFF92 : 16'h0012, 3'h3);
        end
        $display("flag jumps done");
    endtask
    task automatic t_bits;
        logic e;
        logic [7:0] v;
        for (int i = 0; i < 6; i++) begin
            v = i[0] ? 8'h08 : 8'hF7;
            put(8'h21, v);
            pc <= 16'h0100;
            e = (i[2:1] == 2'h1) ? !i[0] : i[0];
            issue(bops[i[2:1]], 8'h0B, 8'h7F);
            chk_br(e, e ? 16'h0182 : 16'h0103, 3'h4);
            @(posedge clk);
            chk(at(8'h21), (i[2:1] == 2'h2 && i[0]) ? 8'h00 : v, "bit byte");
        end
        $display("bit jumps done");
    endtask
    task automatic t_cmp;
        bank <= 2'h2;
        acc <= 8'h5A;
        pc <= 16'h2000;
        put(8'h30, 8'h5A);
        put(8'h10, 8'h50);
        put(8'h11, 8'h51);
        put(8'h50, 8'hAA);
        put(8'h51, 8'h55);
        issue(8'hB5, 8'h30, 8'hFE);
        chk_br(1'b0, 16'h2003, 3'h4);
        issue(8'hB4, 8'h5B, 8'hFE);
        chk_br(1'b1, 16'h2001, 3'h4);
        issue(8'hB6, 8'hAA, 8'hFE);
        chk_br(1'b0, 16'h2003, 3'h4);
        issue(8'hB7, 8'hAA, 8'hFE);
        chk_br(1'b1, 16'h2001, 3'h4);
        for (int r = 0; r < 8; r++) begin
            put({5'h02, r[2:0]}, 8'h40 + r[7:0]);
            issue({5'h17, r[2:0]}, 8'h43, 8'hFE);
            chk_br(r != 3, (r != 3) ? 16'h2001 : 16'h2003, 3'h4);
        end
        $display("compares done");
    endtask
    task automatic t_dec;
        bank <= 2'h1;
        pc <= 16'h3000;
        for (int r = 0; r < 8; r++) begin
            put({5'h01, r[2:0]}, {7'h00, r[0]});
            issue({5'h1B, r[2:0]}, 8'h05, 8'h00);
            chk_br(!r[0], r[0] ? 16'h3002 : 16'h3007, 3'h3);
            @(posedge clk);
            chk(at({5'h01, r[2:0]}), r[0] ? 8'h00 : 8'hFF, "dec reg");
        end
        put(8'h45, 8'h01);
        issue(8'hD5, 8'h45, 8'h10);
        chk_br(1'b0, 16'h3003, 3'h4);
        @(posedge clk);
        chk(at(8'h45), 16'h0000, "dec direct");
        $display("decrements done");
    endtask
    task automatic t_carry;
        logic e;
        for (int i = 0; i < 20; i++) begin
            cy <= i[1];
            put(8'h21, i[0] ? 8'h08 : 8'hF7);
            case (i / 4)
                0: e = i[1] & i[0];
                1: e = i[1] & !i[0];
                2: e = i[1] | i[0];
                3: e = i[1] | !i[0];
                default: e = i[0];
            endcase
            issue(cops[i / 4], 8'h0B, 8'h00);
            chk({r_cwe, r_cy, ncyc}, {1'b1, e, 3'h2}, "carry op");
            @(posedge clk);
            chk(at(8'h21), i[0] ? 8'h08 : 8'hF7, "source bit");
        end
        for (int i = 0; i < 2; i++) begin
            cy <= i[0];
            put(8'h21, i[0] ? 8'h00 : 8'hFF);
            issue(8'h92, 8'h0B, 8'h00);
            chk(ncyc, 3'h3, "copy cycles");
            @(posedge clk);
            chk(at(8'h21), i[0] ? 8'h08 : 8'hF7, "bit copy");
        end
        $display("carry ops done");
    endtask
    task automatic results;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // about 60 instructions of at most 6 cycles each, so 5000 cycles is ample
    initial begin
        #40000;
        failures++;
        results();
    end
    initial begin
        {vld, cy, op, o1, o2, acc, pc, dp, bank} = '0;
        rst_n = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_jumps();
        t_bits();
        t_cmp();
        t_dec();
        t_carry();
        results();
    end
endmodule // bbd_branch_bit_decoder_tb

bind bbd_branch_bit_decoder bbd_monitor bbd_monitor_i (.REF_CLK_I, .RESET_N_I, .INSTR_VALID_I, .INSTR_READY_O,
    .OPCODE_I, .OPERAND1_I, .PC_I, .ACC_I, .DATA_POINTER_I, .CARRY_I, .BYTE_WR_EN_O, .BIT_WR_EN_O,
    .CARRY_WR_EN_O, .DONE_O, .TAKEN_O, .NEXT_PC_O);
